// file: logic/msr_router.sv
// Music stream router: takes messages of three streams, delivers them to the
// internal engine and to the external interface under per-stream enables.
// Assumes selector pulses are one cycle wide and synchronous to clk; the
// panel-forward setting is held by non-volatile storage outside this block.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Three streams: main 1, link 2, sequencer 3.
// - Selectors 1-3 gate internal delivery per stream.
// - Selectors 4-6 gate external transmit per stream.
// - Each selector press toggles enable and indicator.
// - Main local off blocks programs to workspace.
// - Power-up: local enables on, transmit off.
// - Program switch alone adds program messages.
// - Program switch alone still suppresses parameter messages.
// - Panel switch on sends every class.
// - Performance class always eligible on enabled streams.
// - Remote programs 1 to 50 map one-to-one.
// - Both switches off sends performance class only.
// - Panel switch setting survives power cycles.
module msr_router
  import msr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [5:0]  sel_press,
  input  wire logic        panel_forward_switch,
  input  wire logic        program_forward_switch,
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire msr_msg_type in_msg,
  output logic             local_valid,
  output msr_msg_type      local_msg,
  output logic             ws_prog_valid,
  output logic [7:0]       ws_prog_num,
  output logic             xmit_valid,
  input  wire logic        xmit_ready,
  output msr_msg_type      xmit_msg,
  output logic             xmit_prog_range_err,
  output logic [5:0]       sel_led
);

  typedef struct packed {
    logic [2:0]  local_en;
    logic [2:0]  xmit_en;
    logic        local_valid;
    msr_msg_type local_msg;
    logic        ws_prog_valid;
    logic [7:0]  ws_prog_num;
    logic        xmit_valid;
    msr_msg_type xmit_msg;
    logic        range_err;
  } msr_router_state_type;

  msr_router_state_type st_reg;
  msr_router_state_type st_next;

  logic        buf_valid;
  logic        buf_ready;
  msr_msg_type buf_msg;
  logic        class_ok;
  logic [2:0]  hot;
  logic        want_xmit;
  logic        want_local;
  logic        out_free;

  // The buffer absorbs a stalled transmitter so no incoming word is lost.
  msr_skid_buf u_buf (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (in_msg),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_msg)
  );

  msr_filter u_filter (
    .mclass                 (buf_msg.mclass),
    .panel_forward_switch   (panel_forward_switch),
    .program_forward_switch (program_forward_switch),
    .allow                  (class_ok)
  );

  assign hot        = msr_stream_bit(buf_msg.stream);
  assign want_local = |(hot & st_reg.local_en);
  assign want_xmit  = |(hot & st_reg.xmit_en) && class_ok;
  // The output stage takes a word only when its transmit slot is free.
  assign out_free   = !st_reg.xmit_valid || xmit_ready;
  assign buf_ready  = out_free;

  always_comb begin
    st_next = st_reg;
    st_next.local_valid   = 1'b0;
    st_next.ws_prog_valid = 1'b0;
    st_next.range_err     = 1'b0;
    if (st_reg.xmit_valid && xmit_ready) begin
      st_next.xmit_valid = 1'b0;
    end
    // Toggling while keys are held may strand notes; that is left to the user.
    st_next.local_en = st_reg.local_en ^ sel_press[2:0];
    st_next.xmit_en  = st_reg.xmit_en ^ sel_press[5:3];
    if (buf_valid && out_free) begin
      if (want_local) begin
        st_next.local_valid = 1'b1;
        st_next.local_msg   = buf_msg;
        if (buf_msg.stream == MSR_STREAM_MAIN && buf_msg.mclass == MSR_CLASS_PROG) begin
          st_next.ws_prog_valid = 1'b1;
          st_next.ws_prog_num   = buf_msg.prog_num;
        end
      end
      if (want_xmit) begin
        st_next.xmit_valid = 1'b1;
        st_next.xmit_msg   = buf_msg;
        // Numbers past the remote's range have no defined result there.
        if (buf_msg.mclass == MSR_CLASS_PROG &&
            (buf_msg.prog_num == 8'h00 || buf_msg.prog_num > MSR_REMOTE_PROG_MAX)) begin
          st_next.range_err = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg          <= '0;
      st_reg.local_en <= MSR_LOCAL_EN_RESET;
      st_reg.xmit_en  <= MSR_XMIT_EN_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign local_valid         = st_reg.local_valid;
  assign local_msg           = st_reg.local_msg;
  assign ws_prog_valid       = st_reg.ws_prog_valid;
  assign ws_prog_num         = st_reg.ws_prog_num;
  assign xmit_valid          = st_reg.xmit_valid;
  assign xmit_msg            = st_reg.xmit_msg;
  assign xmit_prog_range_err = st_reg.range_err;
  assign sel_led             = {st_reg.xmit_en, st_reg.local_en};

  a_reset_defaults : assert property (@(posedge clk)
    sys_rst |=> (sel_led == 6'h07)) else $error("power-up enables wrong");

  a_sel_toggle : assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> sel_led == ($past(sel_led) ^ $past(sel_press)))
    else $error("selector did not toggle its enable");

  a_param_blocked : assert property (@(posedge clk) disable iff (sys_rst)
    (xmit_valid && !$past(xmit_valid && !xmit_ready) && !$past(panel_forward_switch))
      |-> xmit_msg.mclass != MSR_CLASS_PARAM) else $error("parameter sent without panel");

  a_prog_gate : assert property (@(posedge clk) disable iff (sys_rst)
    (buf_valid && out_free && !panel_forward_switch && !program_forward_switch &&
     buf_msg.mclass == MSR_CLASS_PROG) |=> !xmit_valid)
    else $error("program sent with both switches off");

  a_panel_all : assert property (@(posedge clk) disable iff (sys_rst)
    (buf_valid && out_free && panel_forward_switch && |(hot & st_reg.xmit_en))
      |=> xmit_valid) else $error("panel switch failed to pass message");

  a_perf_pass : assert property (@(posedge clk) disable iff (sys_rst)
    (buf_valid && out_free && buf_msg.mclass == MSR_CLASS_PERF && |(hot & st_reg.xmit_en))
      |=> xmit_valid) else $error("performance message not sent");

  a_prog_switch : assert property (@(posedge clk) disable iff (sys_rst)
    (buf_valid && out_free && program_forward_switch && buf_msg.mclass == MSR_CLASS_PROG
     && |(hot & st_reg.xmit_en)) |=> xmit_valid) else $error("program message not sent");

  a_main_ws : assert property (@(posedge clk) disable iff (sys_rst)
    ws_prog_valid |-> $past(st_reg.local_en[0])) else $error("workspace fed with main off");

  a_local_gate : assert property (@(posedge clk) disable iff (sys_rst)
    (buf_valid && out_free && !want_local) |=> !local_valid)
    else $error("local delivery despite disabled stream");

  a_range_flag : assert property (@(posedge clk) disable iff (sys_rst)
    (buf_valid && out_free && want_xmit && buf_msg.mclass == MSR_CLASS_PROG &&
     buf_msg.prog_num > MSR_REMOTE_PROG_MAX) |=> xmit_prog_range_err)
    else $error("out-of-range program not flagged");

  c_both_paths : cover property (@(posedge clk) local_valid && xmit_valid);
  c_xmit_stall : cover property (@(posedge clk) (xmit_valid && !xmit_ready) [*2]);
  c_ws_prog    : cover property (@(posedge clk) ws_prog_valid);
  c_range_err  : cover property (@(posedge clk) xmit_prog_range_err);

endmodule
`default_nettype wire

// file: logic/msr_pkg.sv
// Package for the music stream router: stream numbering, message classes,
// power-on defaults and the message carrier.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
package msr_pkg;

  localparam int unsigned MSR_NUM_STREAMS = 3;
  localparam logic [1:0] MSR_STREAM_MAIN = 2'h1;
  localparam logic [1:0] MSR_STREAM_LINK = 2'h2;
  localparam logic [1:0] MSR_STREAM_SEQ  = 2'h3;

  localparam int unsigned MSR_LOCAL_SEL_BASE = 1;
  localparam int unsigned MSR_XMIT_SEL_BASE  = 4;

  localparam logic [2:0] MSR_LOCAL_EN_RESET = 3'h7;
  localparam logic [2:0] MSR_XMIT_EN_RESET  = 3'h0;
  localparam logic       MSR_PANEL_FWD_DEFAULT = 1'h0;

  localparam logic [7:0] MSR_REMOTE_PROG_MAX = 8'h32;
  localparam int unsigned MSR_PAYLOAD_W = 16;

  typedef enum logic [1:0] {
    MSR_CLASS_PERF  = 2'b00,
    MSR_CLASS_PROG  = 2'b01,
    MSR_CLASS_PARAM = 2'b10
  } msr_class_type;

  typedef struct packed {
    logic [1:0]               stream;
    msr_class_type            mclass;
    logic [7:0]               prog_num;
    logic [MSR_PAYLOAD_W-1:0] payload;
  } msr_msg_type;

  // Maps a stream number (1 main, 2 link, 3 sequencer) to its one-hot enable bit.
  function automatic logic [2:0] msr_stream_bit(input logic [1:0] stream);
    logic [2:0] hot;
    hot = 3'h0;
    case (stream)
      MSR_STREAM_MAIN: hot = 3'h1;
      MSR_STREAM_LINK: hot = 3'h2;
      MSR_STREAM_SEQ:  hot = 3'h4;
      default:         hot = 3'h0;
    endcase
    return hot;
  endfunction

endpackage

// file: logic/msr_skid_buf.sv
// Two-entry buffer with valid and ready on both sides for message words.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module msr_skid_buf
  import msr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire msr_msg_type in_data,
  output logic             out_valid,
  input  wire logic        out_ready,
  output msr_msg_type      out_data
);

  typedef struct packed {
    msr_msg_type [1:0] mem;
    logic              rd_ptr;
    logic              wr_ptr;
    logic [1:0]        count;
  } msr_buf_state_type;

  msr_buf_state_type st_reg;
  msr_buf_state_type st_next;
  logic              push;
  logic              pop;

  assign in_ready  = (st_reg.count != 2'h2);
  assign out_valid = (st_reg.count != 2'h0);
  assign out_data  = st_reg.mem[st_reg.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr_ptr] = in_data;
      st_next.wr_ptr = ~st_reg.wr_ptr;
    end
    if (pop) begin
      st_next.rd_ptr = ~st_reg.rd_ptr;
    end
    if (push && !pop) begin
      st_next.count = st_reg.count + 2'h1;
    end else if (pop && !push) begin
      st_next.count = st_reg.count - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  a_buf_no_over : assert property (@(posedge clk) disable iff (sys_rst)
    st_reg.count <= 2'h2) else $error("buffer count exceeds two");

endmodule
`default_nettype wire

// file: logic/msr_filter.sv
// Outgoing class filter: decides whether a message class may be transmitted
// from the panel-forward and program-forward switches.
// Assumes pure combinational use inside the router.
`timescale 1ns/1ps
`default_nettype none
module msr_filter
  import msr_pkg::*;
(
  input  wire msr_class_type mclass,
  input  wire logic          panel_forward_switch,
  input  wire logic          program_forward_switch,
  output logic               allow
);

  always_comb begin
    allow = 1'b0;
    if (panel_forward_switch) begin
      allow = 1'b1;
    end else begin
      case (mclass)
        MSR_CLASS_PERF:  allow = 1'b1;
        MSR_CLASS_PROG:  allow = program_forward_switch;
        MSR_CLASS_PARAM: allow = 1'b0;
        default:         allow = 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

// file: dv/msr_sink_model.sv
// Receiver on the router's outgoing side: ready always, ready at random,
// or a full stall, as the bench selects.
// Assumes one clock; the mode changes just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module msr_sink_model
(
  input  wire logic       clk,
  input  wire logic [1:0] stall_mode,
  output logic            xmit_ready
);
  initial xmit_ready = 1'b1;
  // A real receiver may drop ready at any cycle, with or without a word waiting.
  always @(posedge clk) begin
    #1;
    case (stall_mode)
      2'h0: xmit_ready = 1'b1;
      2'h1: xmit_ready = 1'($urandom_range(1));
      default: xmit_ready = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the music stream router.
// Assumes the router package and the sink model in msr_sink_model.sv.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import msr_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [5:0]  sel_press = 6'h00;
  logic        panel_forward_switch = 1'b0;
  logic        program_forward_switch = 1'b0;
  logic        in_valid = 1'b0;
  msr_msg_type in_msg = '0;
  logic        in_ready, local_valid, ws_prog_valid, xmit_valid, xmit_ready;
  logic        xmit_prog_range_err;
  msr_msg_type local_msg, xmit_msg;
  logic [7:0]  ws_prog_num;
  logic [5:0]  sel_led, en_m, tgt;
  logic [1:0]  stall_mode = 2'h0;
  int          fail_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  logic [28:0] q_loc[$], q_xm[$], q_ws[$];
  logic        xm_stuck = 1'b0;
  logic        xm_err = 1'b0;

  msr_router i_dut (.clk(clk), .sys_rst(sys_rst), .sel_press(sel_press),
    .panel_forward_switch(panel_forward_switch),
    .program_forward_switch(program_forward_switch), .in_valid(in_valid),
    .in_ready(in_ready), .in_msg(in_msg), .local_valid(local_valid),
    .local_msg(local_msg), .ws_prog_valid(ws_prog_valid), .ws_prog_num(ws_prog_num),
    .xmit_valid(xmit_valid), .xmit_ready(xmit_ready), .xmit_msg(xmit_msg),
    .xmit_prog_range_err(xmit_prog_range_err), .sel_led(sel_led));
  msr_sink_model i_sink (.clk(clk), .stall_mode(stall_mode), .xmit_ready(xmit_ready));

  always #5 clk = ~clk;

  task automatic check(input logic [28:0] got, input logic [28:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Outputs are sampled on the falling edge, where they have settled.
  // An empty queue yields an unknown note, so any surplus result mismatches.
  // The range flag pulses only in the first cycle of a new word, so it is
  // captured then and compared with the word at its handshake.
  always @(negedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      test_done();
    end else if (!sys_rst) begin
      if (local_valid === 1'b1)
        check(29'(local_msg), q_loc.size() ? q_loc.pop_front() : 'x);
      if (xmit_valid === 1'b1 && xm_stuck !== 1'b1) xm_err = xmit_prog_range_err;
      if (xmit_valid === 1'b1 && xmit_ready === 1'b1)
        check({xm_err, xmit_msg}, q_xm.size() ? q_xm.pop_front() : 'x);
      if (ws_prog_valid === 1'b1)
        check(29'(ws_prog_num), q_ws.size() ? q_ws.pop_front() : 'x);
      xm_stuck = xmit_valid && !xmit_ready;
    end else begin
      xm_stuck = 1'b0;
    end
  end

  // One idle cycle follows each press so the strobe is never set and cleared at once.
  task automatic toggle(input int i);
    sel_press[i] = 1'b1;
    @(posedge clk);
    #1;
    sel_press = 6'h00;
    en_m[i] = ~en_m[i];
    check(29'(sel_led), 29'(en_m));
    @(posedge clk);
    #1;
  endtask

  task automatic send(input msr_msg_type m);
    logic [2:0] hot;
    logic       ok;
    in_valid = 1'b1;
    in_msg = m;
    while (in_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    hot = (m.stream == 2'h0) ? 3'h0 : 3'(3'h1 << (m.stream - 2'h1));
    if ((en_m[2:0] & hot) != 3'h0) q_loc.push_back(29'(m));
    if (hot[0] && en_m[0] && m.mclass == MSR_CLASS_PROG)
      q_ws.push_back(29'(m.prog_num));
    ok = m.mclass == MSR_CLASS_PERF || panel_forward_switch ||
      (program_forward_switch && m.mclass == MSR_CLASS_PROG);
    if (ok && (en_m[5:3] & hot) != 3'h0)
      q_xm.push_back({m.mclass == MSR_CLASS_PROG &&
        (m.prog_num == 8'h0 || m.prog_num > MSR_REMOTE_PROG_MAX), m});
    #1;
  endtask

  // Enables change only with the pipeline empty, as with no keys held.
  task automatic drain;
    in_valid = 1'b0;
    for (int n = 0; n < 400 && q_loc.size() + q_xm.size() + q_ws.size() != 0; n++) begin
      @(posedge clk);
      #1;
    end
    // Any result still owed here was lost inside the router.
    check(29'(q_loc.size() + q_xm.size() + q_ws.size()), 29'h0);
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic do_reset;
    sys_rst = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    en_m = 6'h07;
    check(29'(sel_led), 29'h07);
  endtask

  initial begin
    msr_msg_type m;
    logic        seen;
    void'($urandom(38));
    do_reset();
    for (int i = 0; i < 12; i++) toggle(i % 6);
    for (int k = 0; k < 8; k++) begin
      panel_forward_switch = k[0];
      program_forward_switch = k[1];
      stall_mode = k[2] ? 2'h1 : 2'h0;
      tgt = (k == 7) ? 6'h3f : 6'($urandom);
      for (int i = 0; i < 6; i++) if (en_m[i] != tgt[i]) toggle(i);
      for (int j = 0; j < 16; j++) begin
        m = msr_msg_type'(28'($urandom));
        m.mclass = msr_class_type'($urandom_range(2));
        m.prog_num = 8'((j % 4 == 0) ? 0 : 47 + j % 6);
        send(m);
      end
      drain();
    end
    // With the receiver stalled the input must refuse rather than lose words.
    stall_mode = 2'h2;
    fork
      for (int j = 0; j < 6; j++) send(msr_msg_type'({2'h1, 2'h0, 24'($urandom)}));
      begin
        repeat (30) @(posedge clk);
        #2;
        seen = in_ready;
        stall_mode = 2'h0;
      end
    join
    check(29'(seen), 29'h0);
    drain();
    do_reset();
    toggle(0);
    send(msr_msg_type'({2'h1, MSR_CLASS_PROG, 8'h05, 16'h1234}));
    drain();
    test_done();
  end
endmodule
`default_nettype wire
